// ==== cpb_params.svh ====
// Constants for the configuration-port base relocation block
`ifndef CPB_PARAMS_SVH
`define CPB_PARAMS_SVH

// Configuration register indices
`define CPB_IDX_TEST_TWO   8'h10
`define CPB_IDX_TEST_THREE 8'h11
`define CPB_IDX_BASE_LOW   8'h12
`define CPB_IDX_BASE_HIGH  8'h13

// Reset values
`define CPB_TEST_RST       8'h00
`define CPB_IDX_RST        8'h00
`define CPB_LOW_STRAP0     8'h2E
`define CPB_LOW_STRAP1     8'h4E
`define CPB_HIGH_STRAP0    8'h00
`define CPB_HIGH_STRAP1    8'h16

// Strap bit positions
`define CPB_STRAP_LOW_BIT  0
`define CPB_STRAP_HIGH_BIT 1

// Port select: address bit 0 picks index (0) or data (1) port
`define CPB_PORT_BIT       0
`define CPB_PORT_INDEX     1'b0
`define CPB_PORT_DATA      1'b1

// Base address: bit 0 is always zero
`define CPB_BASE_A0_BIT    0
`define CPB_BASE_A0_VAL    1'b0

// Value read back from an index this block does not hold
`define CPB_UNMAPPED_READ  8'h00

`endif

// ==== cpb_pkg.sv ====
// Types for the configuration-port base relocation block
package cpb_pkg;

	// One I/O cycle as presented by the bus front end
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cpb_io_req_t;

	// Whole state of the register bank
	typedef struct packed {
		logic [7:0]  cfg_idx;
		logic [7:0]  test_two;
		logic [7:0]  test_three;
		logic [7:0]  base_low;
		logic [7:0]  base_high;
		logic [15:0] active_base;
		logic        claim;
		logic [7:0]  rdata;
	} cpb_state_t;

endpackage : cpb_pkg

// ==== cpb_decode.sv ====
// Configuration-port address decoder
`include "cpb_params.svh"
module cpb_decode (
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_base,
	output logic             o_hit,
	output logic             o_data_port
);

	assign o_hit       = (i_addr[15:1] == i_base[15:1]);
	assign o_data_port = (i_addr[`CPB_PORT_BIT] == `CPB_PORT_DATA);

endmodule : cpb_decode

// ==== cpb_regs.sv ====
// Configuration-port base relocation register bank
`include "cpb_params.svh"
// Summary of operation
// - Third test register accessed only in config state with its index loaded.
// - Both test registers are plain storage, cleared on power-on reset.
// - Base held as low byte (bits 7:0) and high byte (bits 15:8).
// - Configuration-port base always sits on an even address.
// - Low base bit 0 is read-only zero regardless of writes.
// - Both resets load low base 0x2E or 0x4E from first strap.
// - Resets load high base 0x00 or 0x16 from second strap.
// - Decode moves only when the high base register is written or on either reset.
module cpb_regs (
	input  wire logic                 I_CLK,
	input  wire logic                 I_SRST,
	input  wire logic                 I_BUS_RST,
	input  wire logic [1:0]           I_BASE_SELECT_STRAP,
	input  wire logic                 I_CFG_STATE,
	input  wire cpb_pkg::cpb_io_req_t I_IO_REQ,
	output logic                      O_CLAIM,
	output logic [7:0]                O_RDATA,
	output logic [15:0]               O_ACTIVE_BASE
);

	cpb_pkg::cpb_state_t st;
	cpb_pkg::cpb_state_t next_st;
	logic                hit;
	logic                data_port;
	logic [7:0]          strap_low;
	logic [7:0]          strap_high;
	logic                data_wr;
	logic                data_rd;

	cpb_decode u_decode (
		.i_addr      (I_IO_REQ.addr),
		.i_base      (st.active_base),
		.o_hit       (hit),
		.o_data_port (data_port)
	);

	assign strap_low = I_BASE_SELECT_STRAP[`CPB_STRAP_LOW_BIT] ?
		`CPB_LOW_STRAP1 : `CPB_LOW_STRAP0;
	assign strap_high = I_BASE_SELECT_STRAP[`CPB_STRAP_HIGH_BIT] ?
		`CPB_HIGH_STRAP1 : `CPB_HIGH_STRAP0;

	// Data port only opens in config state, otherwise it is inert
	assign data_wr = I_IO_REQ.valid && hit && data_port &&
		I_IO_REQ.write && I_CFG_STATE;
	assign data_rd = I_IO_REQ.valid && hit && data_port &&
		!I_IO_REQ.write && I_CFG_STATE;

	always_comb begin
		next_st = st;
		next_st.claim = 1'b0;
		next_st.rdata = `CPB_UNMAPPED_READ;
		if (I_IO_REQ.valid && hit) begin
			next_st.claim = 1'b1;
		end
		// Index port loads only in config state
		if (I_IO_REQ.valid && hit && !data_port && I_CFG_STATE) begin
			if (I_IO_REQ.write) begin
				next_st.cfg_idx = I_IO_REQ.wdata;
			end else begin
				next_st.rdata = st.cfg_idx;
			end
		end
		if (data_wr) begin
			case (st.cfg_idx)
				`CPB_IDX_TEST_TWO: begin
					next_st.test_two = I_IO_REQ.wdata;
				end
				`CPB_IDX_TEST_THREE: begin
					next_st.test_three = I_IO_REQ.wdata;
				end
				`CPB_IDX_BASE_LOW: begin
					next_st.base_low = {I_IO_REQ.wdata[7:1],
						`CPB_BASE_A0_VAL};
				end
				`CPB_IDX_BASE_HIGH: begin
					next_st.base_high = I_IO_REQ.wdata;
					// decode moves here, using the held low byte
					next_st.active_base = {I_IO_REQ.wdata, st.base_low};
				end
				default: begin
					next_st.cfg_idx = st.cfg_idx;
				end
			endcase
		end
		if (data_rd) begin
			case (st.cfg_idx)
				`CPB_IDX_TEST_TWO: begin
					next_st.rdata = st.test_two;
				end
				`CPB_IDX_TEST_THREE: begin
					next_st.rdata = st.test_three;
				end
				`CPB_IDX_BASE_LOW: begin
					next_st.rdata = st.base_low;
				end
				`CPB_IDX_BASE_HIGH: begin
					next_st.rdata = st.base_high;
				end
				default: begin
					next_st.rdata = `CPB_UNMAPPED_READ;
				end
			endcase
		end
		// Bus reset moves the base back but keeps the test registers
		if (I_BUS_RST) begin
			next_st.test_two = st.test_two;
			next_st.test_three = st.test_three;
			next_st.cfg_idx = `CPB_IDX_RST;
			next_st.base_low = strap_low;
			next_st.base_high = strap_high;
			next_st.active_base = {strap_high, strap_low};
			next_st.claim = 1'b0;
			next_st.rdata = `CPB_UNMAPPED_READ;
		end
	end

	// Straps sampled by the synchronous reset, so no async capture hazard
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			st.cfg_idx <= `CPB_IDX_RST;
			st.test_two <= `CPB_TEST_RST;
			st.test_three <= `CPB_TEST_RST;
			st.base_low <= strap_low;
			st.base_high <= strap_high;
			st.active_base <= {strap_high, strap_low};
			st.claim <= 1'b0;
			st.rdata <= `CPB_UNMAPPED_READ;
		end else begin
			st <= next_st;
		end
	end

	assign O_CLAIM = st.claim;
	assign O_RDATA = st.rdata;
	assign O_ACTIVE_BASE = st.active_base;

	sequence cpb_hi_write_s;
		data_wr && st.cfg_idx == `CPB_IDX_BASE_HIGH && !I_BUS_RST;
	endsequence

	sequence cpb_lo_write_s;
		data_wr && st.cfg_idx == `CPB_IDX_BASE_LOW && !I_BUS_RST;
	endsequence

	sequence cpb_test3_write_s;
		data_wr && st.cfg_idx == `CPB_IDX_TEST_THREE && !I_BUS_RST;
	endsequence

	test3_gate_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		!(data_wr && st.cfg_idx == `CPB_IDX_TEST_THREE) && !I_BUS_RST
		|=> st.test_three == $past(st.test_three))
		else $error("Test register three changed without gated write");
	test3_store_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		cpb_test3_write_s |=> st.test_three == $past(I_IO_REQ.wdata))
		else $error("Test register three missed its write");

	test_clear_a: assert property (@(posedge I_CLK)
		I_SRST |=> st.test_two == `CPB_TEST_RST &&
			st.test_three == `CPB_TEST_RST)
		else $error("Test registers not cleared by power-on reset");

	base_even_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		st.active_base[`CPB_BASE_A0_BIT] == `CPB_BASE_A0_VAL)
		else $error("Active base not on an even address");

	low_bit0_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		cpb_lo_write_s |=> st.base_low[`CPB_BASE_A0_BIT] == 1'b0 &&
			st.base_low[7:1] == $past(I_IO_REQ.wdata[7:1]))
		else $error("Low base bit 0 not forced to zero");

	low_strap_a: assert property (@(posedge I_CLK)
		(I_SRST || I_BUS_RST) |=> st.base_low ==
			($past(I_BASE_SELECT_STRAP[`CPB_STRAP_LOW_BIT]) ?
			`CPB_LOW_STRAP1 : `CPB_LOW_STRAP0))
		else $error("Low base reset value wrong for strap");

	high_strap_a: assert property (@(posedge I_CLK)
		(I_SRST || I_BUS_RST) |=> st.base_high ==
			($past(I_BASE_SELECT_STRAP[`CPB_STRAP_HIGH_BIT]) ?
			`CPB_HIGH_STRAP1 : `CPB_HIGH_STRAP0))
		else $error("High base reset value wrong for strap");

	high_move_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		cpb_hi_write_s |=> O_ACTIVE_BASE ==
			{$past(I_IO_REQ.wdata), $past(st.base_low)})
		else $error("Decode did not move on high base write");

	low_hold_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		cpb_lo_write_s |=> O_ACTIVE_BASE == $past(O_ACTIVE_BASE))
		else $error("Decode moved on low base write");

	claim_hit_a: assert property (@(posedge I_CLK)
		disable iff (I_SRST || I_BUS_RST)
		I_IO_REQ.valid && I_IO_REQ.addr[15:1] == O_ACTIVE_BASE[15:1]
		|=> O_CLAIM)
		else $error("Matching cycle not claimed");

	claim_miss_a: assert property (@(posedge I_CLK)
		disable iff (I_SRST)
		!(I_IO_REQ.valid && I_IO_REQ.addr[15:1] == O_ACTIVE_BASE[15:1])
		|=> !O_CLAIM)
		else $error("Non-matching cycle claimed");

	cfg_off_read_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_IO_REQ.valid && !I_CFG_STATE |=> O_RDATA == `CPB_UNMAPPED_READ)
		else $error("Read data returned outside configuration state");

	test_keep_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_BUS_RST |=> st.test_two == $past(st.test_two) &&
			st.test_three == $past(st.test_three))
		else $error("Bus reset disturbed the test registers");

endmodule : cpb_regs

// ==== cpb_host.sv ====
// Host model issuing configuration I/O cycles
module cpb_host (
	input  wire logic            i_clk,
	input  wire logic            i_claim,
	input  wire logic [7:0]      i_rdata,
	output cpb_pkg::cpb_io_req_t o_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_req = '0;
	task automatic cyc(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] rd, output logic cl);
		@(posedge i_clk);
		#10;
		o_req = '{1'b1, w, a, d};
		@(posedge i_clk);
		#10;
		// Idle bus shows flipped lines, never the old cycle
		o_req = '{1'b0, ~w, ~a, ~d};
		rd = i_rdata;
		cl = i_claim;
	endtask : cyc
endmodule : cpb_host

// ==== tb.sv ====
// Self-checking bench for the configuration-port base registers
`include "cpb_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk = 1'b0;
	logic                 srst = 1'b1;
	logic                 brst = 1'b0;
	logic [1:0]           strap = 2'b00;
	logic                 cfg = 1'b1;
	cpb_pkg::cpb_io_req_t req;
	logic                 claim;
	logic [7:0]           rdata;
	logic [15:0]          abase;
	logic [15:0]          base;
	logic [7:0]           rd;
	logic                 cl;
	int                   n_mismatch = 0;
	int                   check_count = 0;
	always #50 clk = ~clk;
	cpb_regs uut (.I_CLK(clk), .I_SRST(srst), .I_BUS_RST(brst),
		.I_BASE_SELECT_STRAP(strap), .I_CFG_STATE(cfg), .I_IO_REQ(req),
		.O_CLAIM(claim), .O_RDATA(rdata), .O_ACTIVE_BASE(abase));
	cpb_host host (.i_clk(clk), .i_claim(claim), .i_rdata(rdata),
		.o_req(req));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rst(input logic [1:0] s, input logic bus, input int n);
		@(posedge clk);
		#10;
		strap = s;
		brst = bus;
		srst = ~bus;
		repeat (n) @(posedge clk);
		#10;
		srst = 1'b0;
		brst = 1'b0;
		base = {s[1] ? 8'h16 : 8'h00, s[0] ? 8'h4E : 8'h2E};
	endtask : rst
	task automatic rw(input logic [7:0] idx, input logic [7:0] d);
		host.cyc(1'b1, base, idx, rd, cl);
		host.cyc(1'b1, base | 16'h0001, d, rd, cl);
	endtask : rw
	task automatic rr(input logic [7:0] idx, input logic [7:0] exp);
		host.cyc(1'b1, base, idx, rd, cl);
		host.cyc(1'b0, base | 16'h0001, 8'h00, rd, cl);
		chk({7'h00, cl, rd}, {8'h01, exp});
	endtask : rr
	task automatic summarize();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	initial begin
		#(3000 * 100);
		n_mismatch++;
		$display("FAIL at %0t: watchdog expired", $time);
		summarize();
	end
	initial begin
		rst(2'b00, 1'b0, 20);
		for (int s = 0; s < 4; s++) begin
			rst(s[1:0], 1'b0, 2);
			chk(abase, base);
		end
		$display("test straps done");
		rw(`CPB_IDX_TEST_TWO, 8'hA5);
		rw(`CPB_IDX_TEST_THREE, 8'h5A);
		rr(`CPB_IDX_TEST_TWO, 8'hA5);
		rr(`CPB_IDX_TEST_THREE, 8'h5A);
		// Outside configuration state nothing is reachable
		cfg = 1'b0;
		rw(`CPB_IDX_TEST_THREE, 8'hFF);
		rr(`CPB_IDX_TEST_THREE, 8'h00);
		cfg = 1'b1;
		rr(`CPB_IDX_TEST_THREE, 8'h5A);
		rst(2'b10, 1'b1, 1);
		chk(abase, base);
		rr(`CPB_IDX_TEST_THREE, 8'h5A);
		rst(2'b10, 1'b0, 1);
		rr(`CPB_IDX_TEST_TWO, 8'h00);
		rr(`CPB_IDX_TEST_THREE, 8'h00);
		$display("test test-registers done");
		rr(`CPB_IDX_BASE_LOW, 8'h2E);
		rw(`CPB_IDX_BASE_LOW, 8'h35);
		rr(`CPB_IDX_BASE_LOW, 8'h34);
		chk(abase, 16'h162E);
		rw(`CPB_IDX_BASE_HIGH, 8'h12);
		chk(abase, 16'h1234);
		host.cyc(1'b0, base, 8'h00, rd, cl);
		chk({15'h0000, cl}, 16'h0000);
		base = 16'h1234;
		rr(`CPB_IDX_BASE_HIGH, 8'h12);
		host.cyc(1'b0, base, 8'h00, rd, cl);
		chk({7'h00, cl, rd}, {8'h01, `CPB_IDX_BASE_HIGH});
		rw(8'h14, 8'hFF);
		rr(8'h14, 8'h00);
		host.cyc(1'b0, 16'h9235, 8'h00, rd, cl);
		chk({15'h0000, cl}, 16'h0000);
		$display("test relocation done");
		summarize();
	end
endmodule : tb
